// ==== logic/flash_cfg.svh ====
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
// Clock rate of i_mclk in MHz (100 ns period)
`define MCLK_MHZ 10
// Write lockout after power-on reset, least figure in microseconds
`define LOCKOUT_TIME_US 1000
// Host keeps the device deselected this long after supply is good (microseconds)
`define SUPPLY_TO_SELECT_DELAY_US 30
// Default self-timed delays in i_mclk cycles
`define BLOCK_WIPE_CYCLES 1000
`define SLEEP_ENTRY_CYCLES 30
`define WAKE_CYCLES 30
// Default instruction codes
`define OPC_BLOCK_WIPE 8'hD8
`define OPC_WRITE_UNLOCK 8'h06
`define OPC_SLEEP 8'hB9
`define OPC_WAKE 8'hAB
// Frame lengths in link bits
`define BITS_OPCODE_ONLY 6'h08
`define BITS_OPCODE_ADDR 6'h20
`define BITS_MAX 6'h3F
// Address layout
`define ADDR_KEPT_BITS 18
`define SECTOR_LSB 16
// Byte value left in every location of an erased sector
`define ERASED_BYTE 8'hFF
`endif

// ==== logic/flash_pkg.sv ====
`default_nettype none
package flash_pkg;
	typedef enum {
		ST_STANDBY,
		ST_WIPE,
		ST_SLEEP_ENTRY,
		ST_DEEP_PD,
		ST_WAKE
	} pwr_state_t;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic sclk_meta;
		logic sclk_sync;
		logic sclk_prev;
		logic mosi_meta;
		logic mosi_sync;
		logic [31:0] shreg;
		logic [5:0] bits;
		logic [7:0] opcode;
		logic frame_end;
		logic [5:0] frame_bits;
		logic [23:0] frame_addr;
	} link_state_t;
endpackage
`default_nettype wire

// ==== logic/spi_frame_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface spi_frame_if;
	logic frame_end;
	logic [5:0] bits;
	logic [7:0] opcode;
	logic [23:0] addr;
	modport src (output frame_end, output bits, output opcode, output addr);
	modport dst (input frame_end, input bits, input opcode, input addr);
endinterface
`default_nettype wire

// ==== logic/spi_frame_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg.svh"
module spi_frame_rx (
	input wire logic i_mclk, // Core clock
	input wire logic i_srst, // Sync reset, active high
	input wire logic i_ce, // Clock enable
	input wire logic i_cs_n, // Chip select pin, active low
	input wire logic i_sclk, // Serial clock pin
	input wire logic i_mosi, // Serial data in pin
	spi_frame_if.src frm // Decoded frame towards the sequencer
);
	import flash_pkg::*;

	link_state_t s_r;
	link_state_t s_nxt;
	logic sclk_rise;

	////////////////////////////////////////////////////////////////
	// Sync pins, shift bits in MSB first on sampled rising clock edges
	always_comb begin
		s_nxt = s_r;
		s_nxt.cs_meta = i_cs_n;
		s_nxt.cs_sync = s_r.cs_meta;
		s_nxt.cs_prev = s_r.cs_sync;
		s_nxt.sclk_meta = i_sclk;
		s_nxt.sclk_sync = s_r.sclk_meta;
		s_nxt.sclk_prev = s_r.sclk_sync;
		s_nxt.mosi_meta = i_mosi;
		s_nxt.mosi_sync = s_r.mosi_meta;
		s_nxt.frame_end = 1'b0;
		sclk_rise = s_r.sclk_sync & ~s_r.sclk_prev;
		if (!s_r.cs_sync && s_r.cs_prev) begin
			// New frame: restart the bit count
			s_nxt.bits = '0;
		end else if (!s_r.cs_sync && sclk_rise) begin
			s_nxt.shreg = {s_r.shreg[30:0], s_r.mosi_sync};
			if (s_r.bits != `BITS_MAX) begin
				s_nxt.bits = s_r.bits + 6'h01;
			end
			if (s_r.bits == `BITS_OPCODE_ONLY - 6'h01) begin
				s_nxt.opcode = {s_r.shreg[6:0], s_r.mosi_sync};
			end
		end
		// Chip select rise closes the frame and reports its length
		if (s_r.cs_sync && !s_r.cs_prev) begin
			s_nxt.frame_end = 1'b1;
			s_nxt.frame_bits = s_r.bits;
			s_nxt.frame_addr = s_r.shreg[23:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			s_r <= '{cs_meta: 1'b1, cs_sync: 1'b1, cs_prev: 1'b1, default: '0};
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	// Frame outputs
	assign frm.frame_end = s_r.frame_end;
	assign frm.bits = s_r.frame_bits;
	assign frm.opcode = s_r.opcode;
	assign frm.addr = s_r.frame_addr;
endmodule // spi_frame_rx
`default_nettype wire

// ==== logic/flash_erase_powerdown_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg.svh"

module flash_erase_powerdown_ctrl #(
	parameter logic [7:0] OPC_BLOCK_WIPE = `OPC_BLOCK_WIPE, // Sector erase code
	parameter logic [7:0] OPC_WRITE_UNLOCK = `OPC_WRITE_UNLOCK, // Write unlock code
	parameter logic [7:0] OPC_SLEEP = `OPC_SLEEP, // Sleep code
	parameter logic [7:0] OPC_WAKE = `OPC_WAKE, // Wake code
	parameter int SECTOR_BITS = 2, // Sector index width
	parameter int BLOCK_WIPE_CYCLES = `BLOCK_WIPE_CYCLES, // Erase cycle length
	parameter int SLEEP_ENTRY_CYCLES = `SLEEP_ENTRY_CYCLES, // Sleep entry delay
	parameter int WAKE_CYCLES = `WAKE_CYCLES, // Wake delay
	parameter int LOCKOUT_CYCLES = `LOCKOUT_TIME_US * `MCLK_MHZ // Write lockout
) (
	input wire logic i_mclk, // Core clock, 10 MHz
	input wire logic i_srst, // Sync reset, active high
	input wire logic i_ce, // Clock enable, freezes state when low
	input wire logic i_por, // Power-on reset / supply below inhibit
	input wire logic i_cs_n, // Chip select pin, active low
	input wire logic i_sclk, // Serial clock pin
	input wire logic i_mosi, // Serial data in pin
	input wire logic i_other_busy, // Program or write cycle run elsewhere
	input wire logic [(1<<SECTOR_BITS)-1:0] i_sector_protected, // Protected sector map
	output logic o_busy_flag, // Some internal cycle running
	output logic o_write_enable_latch, // Write enable latch
	output logic o_write_lockout, // Post power-up lockout active
	output logic o_deep_powerdown, // In deep power-down
	output logic o_standby, // In standby, nothing running
	output logic o_wipe_start, // One-cycle pulse: erase begins
	output logic o_wipe_active, // Array erase in progress
	output logic [`ADDR_KEPT_BITS-1:0] o_wipe_addr, // Erase address, top bits dropped
	output logic [SECTOR_BITS-1:0] o_wipe_sector, // Sector being erased
	output logic [7:0] o_fill_byte, // Value written to every byte
	output flash_pkg::pwr_state_t o_mode // Sequencer state
);
	import flash_pkg::*;

	localparam int CW = 24;
	localparam logic [CW-1:0] WIPE_LAST = CW'(BLOCK_WIPE_CYCLES - 1);
	localparam logic [CW-1:0] WEL_CLR_AT = CW'(BLOCK_WIPE_CYCLES / 2);
	localparam logic [CW-1:0] SLEEP_LAST = CW'(SLEEP_ENTRY_CYCLES - 1);
	localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);
	localparam logic [CW-1:0] LOCK_LAST = CW'(LOCKOUT_CYCLES - 1);

	typedef struct packed {
		pwr_state_t state;
		logic [CW-1:0] cnt;
		logic [CW-1:0] lock_cnt;
		logic lockout;
		logic write_enable_latch;
		logic wipe_start;
		logic [`ADDR_KEPT_BITS-1:0] wipe_addr;
		logic [7:0] fill;
	} ctrl_state_t;

	ctrl_state_t s_r;
	ctrl_state_t s_nxt;
	logic rst;
	logic busy;
	logic len8;
	logic len32;
	logic [SECTOR_BITS-1:0] sector;

	spi_frame_if frm ();

	////////////////////////////////////////////////////////////////
	// Serial link receiver
	spi_frame_rx u_rx (
		.i_mclk(i_mclk),
		.i_srst(rst),
		.i_ce(i_ce),
		.i_cs_n(i_cs_n),
		.i_sclk(i_sclk),
		.i_mosi(i_mosi),
		.frm(frm)
	);

	// Power-on reset holds everything, as the system reset does
	assign rst = i_srst | i_por;

	// Frame qualifiers
	assign len8 = frm.bits == `BITS_OPCODE_ONLY;
	assign len32 = frm.bits == `BITS_OPCODE_ADDR;
	assign sector = frm.addr[`SECTOR_LSB +: SECTOR_BITS];
	assign busy = (s_r.state == ST_WIPE) | i_other_busy;

	////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.wipe_start = 1'b0;
		s_nxt.fill = `ERASED_BYTE;
		// Write lockout timer after power-on reset
		if (s_r.lockout) begin
			if (s_r.lock_cnt == LOCK_LAST) begin
				s_nxt.lockout = 1'b0;
			end else begin
				s_nxt.lock_cnt = s_r.lock_cnt + CW'(1);
			end
		end
		case (s_r.state)
			ST_STANDBY: begin
				// Any instruction is refused while another cycle runs
				if (frm.frame_end && !i_other_busy) begin
					if (frm.opcode == OPC_WRITE_UNLOCK && len8 && !s_r.lockout) begin
						s_nxt.write_enable_latch = 1'b1;
					end else if (frm.opcode == OPC_BLOCK_WIPE && len32 && s_r.write_enable_latch && !s_r.lockout
							&& !i_sector_protected[sector]) begin
						s_nxt.state = ST_WIPE;
						s_nxt.cnt = '0;
						s_nxt.wipe_start = 1'b1;
						s_nxt.wipe_addr = frm.addr[`ADDR_KEPT_BITS-1:0];
					end else if (frm.opcode == OPC_SLEEP && len8) begin
						s_nxt.state = ST_SLEEP_ENTRY;
						s_nxt.cnt = '0;
					end
				end
			end
			ST_WIPE: begin
				// Frames during the cycle are ignored entirely
				if (s_r.cnt == WEL_CLR_AT) begin
					s_nxt.write_enable_latch = 1'b0;
				end
				if (s_r.cnt == WIPE_LAST) begin
					s_nxt.state = ST_STANDBY;
					s_nxt.write_enable_latch = 1'b0;
				end else begin
					s_nxt.cnt = s_r.cnt + CW'(1);
				end
			end
			ST_SLEEP_ENTRY: begin
				if (s_r.cnt == SLEEP_LAST) begin
					s_nxt.state = ST_DEEP_PD;
				end else begin
					s_nxt.cnt = s_r.cnt + CW'(1);
				end
			end
			ST_DEEP_PD: begin
				// Only an exact wake frame leaves deep power-down
				if (frm.frame_end && !i_other_busy && frm.opcode == OPC_WAKE && len8) begin
					s_nxt.state = ST_WAKE;
					s_nxt.cnt = '0;
				end
			end
			ST_WAKE: begin
				if (s_r.cnt == WAKE_LAST) begin
					s_nxt.state = ST_STANDBY;
				end else begin
					s_nxt.cnt = s_r.cnt + CW'(1);
				end
			end
			default: begin
				s_nxt.state = ST_STANDBY;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// State register; reset lands in standby, latch clear, lockout armed
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			s_r <= '{state: ST_STANDBY, lockout: 1'b1, fill: `ERASED_BYTE, default: '0};
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign o_busy_flag = busy;
	assign o_write_enable_latch = s_r.write_enable_latch;
	assign o_write_lockout = s_r.lockout;
	assign o_deep_powerdown = s_r.state == ST_DEEP_PD;
	assign o_standby = (s_r.state == ST_STANDBY) & ~i_other_busy;
	assign o_wipe_start = s_r.wipe_start;
	assign o_wipe_active = s_r.state == ST_WIPE;
	assign o_wipe_addr = s_r.wipe_addr;
	assign o_wipe_sector = s_r.wipe_addr[`SECTOR_LSB +: SECTOR_BITS];
	assign o_fill_byte = s_r.fill;
	assign o_mode = s_r.state;
endmodule // flash_erase_powerdown_ctrl
`default_nettype wire

// ==== test/flash_erase_powerdown_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg.svh"
module flash_erase_powerdown_ctrl_chk #(
	parameter int SECTOR_BITS = 2 // Sector index width
) (
	input wire logic i_mclk, // Clock
	input wire logic i_srst, // Reset
	input wire logic i_por, // Power-on reset
	input wire logic [(1<<SECTOR_BITS)-1:0] i_sector_protected, // Protect map
	input wire logic o_busy_flag, // Busy
	input wire logic o_write_enable_latch, // Latch
	input wire logic o_write_lockout, // Lockout
	input wire logic o_deep_powerdown, // Deep
	input wire logic o_wipe_start, // Erase pulse
	input wire logic o_wipe_active, // Erasing
	input wire logic [`ADDR_KEPT_BITS-1:0] o_wipe_addr, // Address
	input wire logic [SECTOR_BITS-1:0] o_wipe_sector, // Sector
	input wire logic [7:0] o_fill_byte, // Fill
	input var flash_pkg::pwr_state_t o_mode // State
);
	import flash_pkg::*;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst || i_por);
	//////////////////////////////////////////////////////////////////////////////
	// Erase starts only from an armed latch, with busy shown
	property p_start; o_wipe_start |-> o_wipe_active && o_busy_flag && o_write_enable_latch; endproperty
	a_start: assert property (p_start) else $error("erase start without latch");
	property p_prot; o_wipe_start |-> !i_sector_protected[o_wipe_sector]; endproperty
	a_prot: assert property (p_prot) else $error("protected sector erased");
	property p_busy; o_wipe_active |-> o_busy_flag; endproperty
	a_busy: assert property (p_busy) else $error("busy low while erasing");
	property p_len; $rose(o_wipe_active) |-> o_wipe_active [*8]; endproperty
	a_len: assert property (p_len) else $error("erase cycle cut short");
	property p_wel; $fell(o_wipe_active) |-> !o_write_enable_latch; endproperty
	a_wel: assert property (p_wel) else $error("latch still set after erase");
	property p_lock; o_write_lockout |-> !o_write_enable_latch && !o_wipe_active; endproperty
	a_lock: assert property (p_lock) else $error("write accepted in lockout");
	property p_deep; o_deep_powerdown |=> !o_wipe_start && (o_deep_powerdown || o_mode == ST_WAKE); endproperty
	a_deep: assert property (p_deep) else $error("erase in deep power-down");
	property p_sec;
		o_wipe_active && !o_wipe_start |-> $stable(o_wipe_addr)
			&& o_wipe_sector == o_wipe_addr[`SECTOR_LSB +: SECTOR_BITS] && o_fill_byte == `ERASED_BYTE;
	endproperty
	a_sec: assert property (p_sec) else $error("erase target or fill disturbed");
	property p_por;
		@(posedge i_mclk) disable iff (i_srst) i_por |=> o_mode == ST_STANDBY && !o_write_enable_latch;
	endproperty
	a_por: assert property (p_por) else $error("power-on reset not obeyed");
endmodule // flash_erase_powerdown_ctrl_chk
`default_nettype wire

// ==== test/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic i_mclk, // Clock
	output logic o_cs_n, // Select, active low
	output logic o_sclk, // Link clock
	output logic o_mosi // Data
);
	// Idle bus
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end
	// One frame MSB first at 800 ns; clock parked, data inverted when released
	task automatic send(input logic [31:0] d, input int n);
		@(negedge i_mclk);
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_mosi = d[i];
			repeat (4) @(negedge i_mclk);
			o_sclk = 1'b1;
			repeat (4) @(negedge i_mclk);
			o_sclk = 1'b0;
		end
		repeat (4) @(negedge i_mclk);
		o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		repeat (48) @(negedge i_mclk);
	endtask
endmodule // spi_host_model
`default_nettype wire

// ==== test/flash_erase_powerdown_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module flash_erase_powerdown_ctrl_tb_top;
	import flash_pkg::*;
	localparam int LOCK = 1000;
	logic mclk, srst, por, obusy, cs_n, sclk, mosi, busy, write_enable_latch, lock, deep, wact, stby;
	logic [3:0] prot;
	logic [17:0] waddr;
	logic [1:0] wsec;
	logic [7:0] fill;
	pwr_state_t mode;
	int errors, samples_checked, n;
	logic [31:0] a;
	logic [1:0] secs [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	spi_host_model host (.i_mclk(mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
	flash_erase_powerdown_ctrl #(.BLOCK_WIPE_CYCLES(800), .LOCKOUT_CYCLES(LOCK)) uut (.i_mclk(mclk), .i_srst(srst),
		.i_ce(1'b1), .i_por(por), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .i_other_busy(obusy),
		.i_sector_protected(prot), .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch), .o_write_lockout(lock),
		.o_deep_powerdown(deep), .o_standby(stby), .o_wipe_start(), .o_wipe_active(wact), .o_wipe_addr(waddr),
		.o_wipe_sector(wsec), .o_fill_byte(fill), .o_mode(mode));
	//////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out();
		$display("Checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c);
		host.send({24'h0, c}, 8);
	endtask
	// Bounded wait for the erase to finish
	task automatic wait_idle();
		int t;
		for (t = 0; t < 1000 && busy !== 1'b0; t++)
			@(negedge mclk);
		`CHK("busy", 1'b0, busy)
		if (t == 1000)
			close_out();
	endtask
	// Erase runs only on a whole frame to an unprotected sector
	function automatic logic exp_wipe(int nb, logic [1:0] s);
		return nb == 32 && !prot[s];
	endfunction
	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		errors++;
		close_out();
	end
	// Main sequence
	initial begin
		srst = 1'b1;
		por = 1'b0;
		obusy = 1'b0;
		prot = 4'h2;
		a = $urandom(97);
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		@(negedge mclk);
		`CHK("mode", ST_STANDBY, mode)
		`CHK("wel", 1'b0, write_enable_latch)
		`CHK("fill", `ERASED_BYTE, fill)
		`CHK("standby", 1'b1, stby)
		// Stay deselected after supply is good; lockout must still be running afterwards
		repeat (`SUPPLY_TO_SELECT_DELAY_US * `MCLK_MHZ) @(negedge mclk);
		cmd(`OPC_WRITE_UNLOCK);
		`CHK("wel", 1'b0, write_enable_latch)
		`CHK("lock", 1'b1, lock)
		repeat (LOCK) @(negedge mclk);
		`CHK("lock", 1'b0, lock)
		host.send({`OPC_BLOCK_WIPE, 24'h0}, 32);
		`CHK("mode", ST_STANDBY, mode)
		$display("Test reset done");
		for (int k = 0; k < 4; k++) begin
			n = (k == 0) ? 31 : 32;
			a = $urandom;
			a[17:16] = secs[k];
			cmd(`OPC_WRITE_UNLOCK);
			`CHK("wel", 1'b1, write_enable_latch)
			host.send(n == 32 ? {`OPC_BLOCK_WIPE, a[23:0]} : {1'b0, `OPC_BLOCK_WIPE, a[23:1]}, n);
			`CHK("active", exp_wipe(n, a[17:16]), wact)
			if (exp_wipe(n, a[17:16])) begin
				`CHK("addr", a[17:0], waddr)
				`CHK("sector", a[17:16], wsec)
				host.send({`OPC_BLOCK_WIPE, ~a[23:0]}, 32);
				`CHK("addr", a[17:0], waddr)
				wait_idle();
				`CHK("wel", 1'b0, write_enable_latch)
			end
		end
		$display("Test erase done");
		obusy = 1'b1;
		cmd(`OPC_SLEEP);
		`CHK("mode", ST_STANDBY, mode)
		`CHK("busy", 1'b1, busy)
		`CHK("standby", 1'b0, stby)
		obusy = 1'b0;
		host.send({23'h0, `OPC_SLEEP, 1'b1}, 9);
		`CHK("deep", 1'b0, deep)
		cmd(`OPC_SLEEP);
		`CHK("deep", 1'b1, deep)
		`CHK("standby", 1'b0, stby)
		cmd(`OPC_WRITE_UNLOCK);
		`CHK("wel", 1'b0, write_enable_latch)
		host.send({23'h0, `OPC_WAKE, 1'b0}, 9);
		`CHK("deep", 1'b1, deep)
		obusy = 1'b1;
		cmd(`OPC_WAKE);
		`CHK("deep", 1'b1, deep)
		obusy = 1'b0;
		cmd(`OPC_WAKE);
		`CHK("mode", ST_STANDBY, mode)
		`CHK("standby", 1'b1, stby)
		// Arm the latch so that power-on reset has something to clear
		cmd(`OPC_WRITE_UNLOCK);
		`CHK("wel", 1'b1, write_enable_latch)
		cmd(`OPC_SLEEP);
		por = 1'b1;
		repeat (2) @(negedge mclk);
		por = 1'b0;
		`CHK("deep", 1'b0, deep)
		`CHK("wel", 1'b0, write_enable_latch)
		`CHK("standby", 1'b1, stby)
		`CHK("lock", 1'b1, lock)
		$display("Test power done");
		close_out();
	end
endmodule // flash_erase_powerdown_ctrl_tb_top
bind flash_erase_powerdown_ctrl flash_erase_powerdown_ctrl_chk #(.SECTOR_BITS(SECTOR_BITS)) chk (.i_mclk(i_mclk),
	.i_srst(i_srst), .i_por(i_por), .i_sector_protected(i_sector_protected), .o_busy_flag(o_busy_flag),
	.o_write_enable_latch(o_write_enable_latch), .o_write_lockout(o_write_lockout),
	.o_deep_powerdown(o_deep_powerdown), .o_wipe_start(o_wipe_start), .o_wipe_active(o_wipe_active),
	.o_wipe_addr(o_wipe_addr), .o_wipe_sector(o_wipe_sector), .o_fill_byte(o_fill_byte), .o_mode(o_mode));
`default_nettype wire
